// ==== core/pvip_regs.svh ====
// Constants for the parallel video input port
`ifndef PVIP_REGS_SVH
`define PVIP_REGS_SVH
`define PVIP_FILT_MIN 2'h3
`define PVIP_DATA_W 24
`define PVIP_GPIO0_BIT 0
`define PVIP_GPIO1_BIT 1
`define PVIP_GPIO2_BIT 8
`define PVIP_GPIO3_BIT 9
`define PVIP_GPIO4_BIT 16
`define PVIP_GPIO5_BIT 17
`define PVIP_RST_WORD 27'h0000000
`endif

// ==== core/pvip_pkg.sv ====
// Types for the parallel video input port
package pvip_pkg;
    // One captured pixel word with its controls
    typedef struct packed {
        logic line_sync;
        logic frame_sync;
        logic pixel_valid;
        logic [23:0] color;
    } pvip_word_t;
    // Control qualifier states, stable and count
    typedef enum logic [1:0] {
        PVIP_ST_STABLE = 2'b00,
        PVIP_ST_COUNT = 2'b01
    } pvip_filt_t;
endpackage : pvip_pkg

// ==== core/pvip_buf.sv ====
// Two-entry valid/ready buffer for pixel words
`timescale 1ns/1ps
module pvip_buf (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input pvip_pkg::pvip_word_t in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output pvip_pkg::pvip_word_t out_data
);
    // Storage and occupancy
    pvip_pkg::pvip_word_t mem_r [2];
    logic rd_ptr_r;
    logic wr_ptr_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Full stalls the source; ready is registered from count
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 2'h0;
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            in_ready <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h2;
            out_valid <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h0;
        end
    end
    // Entry writes
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
    assign out_data = mem_r[rd_ptr_r];
endmodule : pvip_buf

// ==== core/pvip_top.sv ====
// Parallel video input stage: capture, control filter, pin sharing
// How it works
// - Filter on: pass line sync/valid after three clocks
// - Filter off: pass sync/valid as sampled
// - Sample on rising or falling selected edge
// - Data 0,1,8,9,16,17 become general I/O 0-5
// - I/O 0-3 only in 18-bit mode
// - 18-bit mode from strap or config bit
// - Audio clock, word, data A become outputs 8,7,6
// - 18-bit mode: second audio data on pin 17
// - Second audio pin: colour 17 or output 5
// - No self test in backward-compatible mode
// - Register-driven outputs 5-8 follow config value
`timescale 1ns/1ps
`include "pvip_regs.svh"
module pvip_top (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Video pins
    input wire logic [23:0] DIN_I,
    input wire logic LINE_SYNC_IN,
    input wire logic FRAME_SYNC_IN,
    input wire logic PIXEL_VALID_IN,
    // General I/O pins on shared data bits
    output logic [5:0] GPIO_O,
    output logic [5:0] GPIO_OE,
    // Audio pins, usable as outputs
    input wire logic [2:0] AUDIO_I,
    output logic [2:0] AUDIO_O,
    output logic [2:0] AUDIO_OE,
    input wire logic SECOND_AUDIO_DATA_IN,
    output logic SECOND_AUDIO_O,
    output logic SECOND_AUDIO_OE,
    // Configuration
    input wire logic STROBE_EDGE_SELECT,
    input wire logic FILTER_EN,
    input wire logic MODE18_STRAP,
    input wire logic MODE18_CFG,
    input wire logic [5:0] GPIO_EN,
    input wire logic [5:0] GPIO_DIR_OUT,
    input wire logic [5:0] GPIO_OUT_VAL,
    input wire logic [8:4] REGISTER_DRIVEN_OUTPUT,
    input wire logic [8:5] REG_OUT_EN,
    input wire logic COMPAT_MODE,
    input wire logic SELF_TEST_REQ,
    // Status and stream out
    output logic MODE18,
    output logic LINK_SELF_TEST,
    output logic [5:0] GPIO_IN,
    output logic [1:0] AUDIO_B_OUT,
    output logic PIX_VALID,
    input wire logic PIX_READY,
    output pvip_pkg::pvip_word_t PIX_WORD,
    output logic CAPTURE_STALL
);
    // Both edges captured; the selected one is used
    pvip_pkg::pvip_word_t rise_r;
    pvip_pkg::pvip_word_t fall_r;
    pvip_pkg::pvip_word_t cap;
    logic [1:0] sd_rise_r;
    logic [1:0] sd_fall_r;
    logic mode18_r;
    logic mode18_nxt;
    logic [5:0] gpio_act;
    pvip_pkg::pvip_word_t filt;
    logic buf_ready;
    logic buf_valid_r;
    pvip_pkg::pvip_word_t buf_word_r;
    logic out_v;
    pvip_pkg::pvip_word_t out_w;

    // Rising-edge capture of every video pin and both audio data pins together
    always_ff @(posedge CORE_CLK) begin
        rise_r <= {LINE_SYNC_IN, FRAME_SYNC_IN, PIXEL_VALID_IN, DIN_I};
        sd_rise_r <= {SECOND_AUDIO_DATA_IN, AUDIO_I[2]};
    end
    // Falling-edge capture, same word layout; no reset, data only
    always_ff @(negedge CORE_CLK) begin
        fall_r <= {LINE_SYNC_IN, FRAME_SYNC_IN, PIXEL_VALID_IN, DIN_I};
        sd_fall_r <= {SECOND_AUDIO_DATA_IN, AUDIO_I[2]};
    end
    assign cap = STROBE_EDGE_SELECT ? rise_r : fall_r;

    // Mode select: strap or configuration bit
    assign mode18_nxt = MODE18_STRAP | MODE18_CFG;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mode18_r <= 1'b0;
        end else begin
            mode18_r <= mode18_nxt;
        end
    end
    assign MODE18 = mode18_r;

    // I/O 0-3 gated by 18-bit mode; 4-5 always offered
    assign gpio_act = GPIO_EN & {2'b11, {4{mode18_r}}};

    // Shared data bits, one generate per general I/O line
    localparam int GPIO_MAP [6] = '{`PVIP_GPIO0_BIT, `PVIP_GPIO1_BIT, `PVIP_GPIO2_BIT,
        `PVIP_GPIO3_BIT, `PVIP_GPIO4_BIT, `PVIP_GPIO5_BIT};
    pvip_pkg::pvip_word_t mapped;
    always_comb begin
        mapped = cap;
        for (int i = 0; i < 6; i++) begin
            // Reassigned bits carry no colour
            if (gpio_act[i]) begin
                mapped.color[GPIO_MAP[i]] = 1'b0;
            end
        end
        // Bit 17 taken from the second audio pin in 18-bit mode, unless output 5 or I/O 5 is enabled
        if (mode18_r && !REG_OUT_EN[5] && !gpio_act[5]) begin
            mapped.color[`PVIP_GPIO5_BIT] = STROBE_EDGE_SELECT ? sd_rise_r[1]
                : sd_fall_r[1];
        end
    end
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_gpio
            always_ff @(posedge CORE_CLK) begin
                if (SYS_RST) begin
                    GPIO_IN[g] <= 1'b0;
                    GPIO_O[g] <= 1'b0;
                    GPIO_OE[g] <= 1'b0;
                end else begin
                    GPIO_IN[g] <= gpio_act[g] & cap.color[GPIO_MAP[g]];
                    GPIO_O[g] <= GPIO_OUT_VAL[g];
                    GPIO_OE[g] <= gpio_act[g] & GPIO_DIR_OUT[g];
                end
            end
        end
    endgenerate

    // Audio pins as register-driven outputs 6-8, second audio as 5
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            AUDIO_O <= 3'h0;
            AUDIO_OE <= 3'h0;
            SECOND_AUDIO_O <= 1'b0;
            SECOND_AUDIO_OE <= 1'b0;
            AUDIO_B_OUT <= 2'h0;
        end else begin
            AUDIO_O <= {REGISTER_DRIVEN_OUTPUT[6], REGISTER_DRIVEN_OUTPUT[7],
                REGISTER_DRIVEN_OUTPUT[8]};
            AUDIO_OE <= {REG_OUT_EN[6], REG_OUT_EN[7], REG_OUT_EN[8]};
            SECOND_AUDIO_O <= REGISTER_DRIVEN_OUTPUT[5];
            SECOND_AUDIO_OE <= REG_OUT_EN[5];
            // Audio data A and, in 18-bit mode, data B
            AUDIO_B_OUT <= {mode18_r & ~REG_OUT_EN[5] & (STROBE_EDGE_SELECT ? sd_rise_r[1]
                : sd_fall_r[1]), STROBE_EDGE_SELECT ? sd_rise_r[0] : sd_fall_r[0]};
        end
    end

    // Self test refused in backward-compatible mode
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            LINK_SELF_TEST <= 1'b0;
        end else begin
            LINK_SELF_TEST <= SELF_TEST_REQ & ~COMPAT_MODE;
        end
    end

    // Control filter: line sync and pixel valid need 3 stable clocks
    // Frame sync is slow by contract, so it is passed straight
    logic [1:0] ls_cnt_r;
    logic [1:0] pv_cnt_r;
    logic ls_q_r;
    logic pv_q_r;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ls_cnt_r <= 2'h0;
            pv_cnt_r <= 2'h0;
            ls_q_r <= 1'b0;
            pv_q_r <= 1'b0;
        end else begin
            // Count cycles the new level has held
            if (mapped.line_sync == ls_q_r) begin
                ls_cnt_r <= 2'h0;
            end else if (ls_cnt_r == `PVIP_FILT_MIN - 2'h1) begin
                ls_q_r <= mapped.line_sync;
                ls_cnt_r <= 2'h0;
            end else begin
                ls_cnt_r <= ls_cnt_r + 2'h1;
            end
            if (mapped.pixel_valid == pv_q_r) begin
                pv_cnt_r <= 2'h0;
            end else if (pv_cnt_r == `PVIP_FILT_MIN - 2'h1) begin
                pv_q_r <= mapped.pixel_valid;
                pv_cnt_r <= 2'h0;
            end else begin
                pv_cnt_r <= pv_cnt_r + 2'h1;
            end
        end
    end
    // Filtered levels lag by three clocks; data is not delayed to match,
    // a trade for area that the downstream framer must tolerate
    always_comb begin
        filt = mapped;
        if (FILTER_EN) begin
            filt.line_sync = ls_q_r;
            filt.pixel_valid = pv_q_r;
        end
        // Filter off: sampled levels pass unchanged
    end

    // Registered word into the buffer, held while it is full
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            buf_valid_r <= 1'b0;
            buf_word_r <= `PVIP_RST_WORD;
            CAPTURE_STALL <= 1'b0;
        end else begin
            CAPTURE_STALL <= buf_valid_r & ~buf_ready;
            if (!buf_valid_r || buf_ready) begin
                buf_valid_r <= 1'b1;
                buf_word_r <= filt;
            end
        end
    end

    pvip_buf u_buf (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .in_valid(buf_valid_r),
        .in_ready(buf_ready),
        .in_data(buf_word_r),
        .out_valid(out_v),
        .out_ready(PIX_READY),
        .out_data(out_w)
    );
    // Stream outputs from flip-flops
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            PIX_VALID <= 1'b0;
            PIX_WORD <= `PVIP_RST_WORD;
        end else begin
            PIX_VALID <= out_v & PIX_READY;
            PIX_WORD <= out_w;
        end
    end

    // Assertions
    a_selftest_blocked: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        $past(COMPAT_MODE) |-> !LINK_SELF_TEST) else $error("self test in compat mode");
    a_gpio_mode_gate: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !$past(mode18_r) |-> GPIO_OE[3:0] == 4'h0) else $error("gpio 0-3 outside 18-bit");
    a_filter_hold: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        $changed(ls_q_r) |-> $past(mapped.line_sync, 1) == ls_q_r
        && $past(mapped.line_sync, 3) == ls_q_r) else $error("short line sync passed");
    a_pv_filter_hold: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        $changed(pv_q_r) |-> $past(mapped.pixel_valid, 3) == pv_q_r)
        else $error("short pixel valid passed");
    // Checked at the buffer input so a broken bypass mux is caught, not just the comb copy
    a_filter_bypass: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        $past(!SYS_RST && !FILTER_EN && (!buf_valid_r || buf_ready))
        |-> buf_word_r.line_sync == $past(mapped.line_sync)) else $error("bypass altered");
    a_mode_select: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ##1 MODE18 == ($past(MODE18_STRAP) | $past(MODE18_CFG))) else $error("mode select");
    a_regout_value: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ##1 AUDIO_O[0] == $past(REGISTER_DRIVEN_OUTPUT[8])) else $error("output 8 value");
    a_second_audio_oe: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        ##1 SECOND_AUDIO_OE == $past(REG_OUT_EN[5])) else $error("output 5 enable");
endmodule : pvip_top

// ==== test/pvip_src_model.sv ====
// Video source model: counting pixel stream with sync and valid controls
`timescale 1ns/1ps
module pvip_src_model (
    // Clock
    input wire logic clk,
    // Control from the bench
    input wire logic run,
    input wire logic [23:0] idle_din,
    // Video pins
    output logic [23:0] din,
    output logic line_sync,
    output logic frame_sync,
    output logic pixel_valid
);
    // ==========
    // Pattern state
    logic [23:0] cnt_r = 24'h000000; // Pixel counter, also the colour word
    initial begin
        din = 24'h000000;
        {line_sync, frame_sync, pixel_valid} = 3'h0;
    end
    // Drive off the falling edge so the sampling edge sees settled pins
    always @(negedge clk) begin
        if (run) begin
            cnt_r <= cnt_r + 24'h000001;
            din <= cnt_r;
            pixel_valid <= (cnt_r % 140) < 70;
            // Two-clock pulse on purpose: short enough to be filtered
            line_sync <= (cnt_r % 140) inside {100, 101};
            frame_sync <= (cnt_r % 280) < 140;
        end else begin
            // Idle: controls low, data follows the bench
            din <= idle_din;
            {line_sync, frame_sync, pixel_valid} <= 3'h0;
        end
    end
endmodule : pvip_src_model

// ==== test/tb_top.sv ====
// Self-checking bench for the parallel video input port
`timescale 1ns/1ps
module tb_top;
    // ==========
    // Signals
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, mon = 1'b0, have = 1'b0, sel = 1'b1;
    logic ls, fs, pv, filt, m_st, m_cfg, compat, st_req, sad, rdy, m18, lst, cst, pxv;
    logic sao, saoe, seen_ls, seen_pv, seen_cst;
    logic [23:0] idle, din, last;
    logic [5:0] g_en, g_dir, g_val, g_o, g_oe, g_in;
    logic [2:0] a_i, a_o, a_oe;
    logic [8:4] rdo;
    logic [8:5] r_en;
    logic [1:0] a_b;
    pvip_pkg::pvip_word_t pw;
    int err_count = 0, cmp_count = 0;
    // ==========
    // Clock, source and design
    always #2 clk = ~clk;
    pvip_src_model src (.clk(clk), .run(run), .idle_din(idle), .din(din), .line_sync(ls),
        .frame_sync(fs), .pixel_valid(pv));
    pvip_top uut (.CORE_CLK(clk), .SYS_RST(rst), .DIN_I(din), .LINE_SYNC_IN(ls),
        .FRAME_SYNC_IN(fs), .PIXEL_VALID_IN(pv), .GPIO_O(g_o), .GPIO_OE(g_oe),
        .AUDIO_I(a_i), .AUDIO_O(a_o), .AUDIO_OE(a_oe), .SECOND_AUDIO_DATA_IN(sad),
        .SECOND_AUDIO_O(sao), .SECOND_AUDIO_OE(saoe), .STROBE_EDGE_SELECT(sel),
        .FILTER_EN(filt), .MODE18_STRAP(m_st), .MODE18_CFG(m_cfg), .GPIO_EN(g_en),
        .GPIO_DIR_OUT(g_dir), .GPIO_OUT_VAL(g_val), .REGISTER_DRIVEN_OUTPUT(rdo),
        .REG_OUT_EN(r_en), .COMPAT_MODE(compat), .SELF_TEST_REQ(st_req), .MODE18(m18),
        .LINK_SELF_TEST(lst), .GPIO_IN(g_in), .AUDIO_B_OUT(a_b), .PIX_VALID(pxv),
        .PIX_READY(rdy), .PIX_WORD(pw), .CAPTURE_STALL(cst));
    // ==========
    // Shared tasks
    task automatic chk(input string nm, input logic [26:0] e, input logic [26:0] g);
        cmp_count++;
        if (e !== g) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic report_and_stop;
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    // ==========
    // Stream monitor: words rise in order, controls stay with their pixel
    // Sampled on the falling edge, where the registered outputs have settled
    always @(negedge clk) begin
        if (mon && pxv === 1'b1) begin
            if (have) chk("color_order", 27'h1, 27'(pw.color > last));
            chk("frame_sync", 27'((pw.color % 280) < 140), 27'(pw.frame_sync));
            if (!filt) chk("pix_valid", 27'((pw.color % 140) < 70), 27'(pw.pixel_valid));
            if (!filt) chk("line_sync", 27'((pw.color % 140) inside {100, 101}), 27'(pw.line_sync));
            seen_ls = seen_ls | (pw.line_sync === 1'b1);
            seen_pv = seen_pv | (pw.pixel_valid === 1'b1);
            last = pw.color;
            have = 1'b1;
        end
        if (mon && cst === 1'b1) seen_cst = 1'b1;
    end
    // ==========
    // Watchdog against a hang; four passes of about 616 cycles plus setup need ~10 us
    initial begin
        #60000;
        err_count++;
        report_and_stop();
    end
    // ==========
    // Main sequence
    initial begin
        {filt, m_st, m_cfg, compat, st_req, sad, g_en, g_dir, g_val, rdo, r_en, a_i} = '0;
        idle = 24'h000000;
        rdy = 1'b1;
        step(3);
        rst = 1'b0;
        step(1);
        chk("reset_outs", 27'h0, 27'({pxv, m18, lst, g_oe, a_oe, saoe}));
        for (int i = 0; i < 4; i++) begin
            {m_st, m_cfg} = 2'(i);
            step(2);
            chk("mode18", 27'(i != 0), 27'(m18));
        end
        for (int i = 0; i < 2; i++) begin
            {compat, st_req} = {1'(i), 1'b1};
            step(2);
            chk("self_test", 27'(i == 0), 27'(lst));
        end
        {m_st, m_cfg, st_req, compat} = 4'h0;
        {g_en, g_dir, g_val} = {6'h3f, 6'h3f, 6'h2a};
        step(3);
        chk("gpio_oe_m24", 27'hc2a, 27'({g_oe, g_o}));
        m_cfg = 1'b1;
        step(3);
        chk("gpio_out_m18", 27'hfea, 27'({g_oe, g_o}));
        {g_dir, idle} = {6'h00, 24'h010102};
        step(4);
        chk("gpio_in", 27'h16, 27'({g_oe, g_in}));
        g_en = 6'h00;
        r_en = 4'hf;
        for (int i = 0; i < 2; i++) begin
            rdo = i ? 5'b01000 : 5'b10110;
            step(3);
            chk("reg_outs", 27'({3'h7, rdo[6], rdo[7], rdo[8], 1'b1, rdo[5]}),
                27'({a_oe, a_o, saoe, sao}));
        end
        {r_en, a_i, sad} = {4'h0, 3'h4, 1'b1};
        for (int i = 0; i < 2; i++) begin
            m_cfg = 1'(1 - i);
            step(3);
            chk("audio_b", 27'({3'h0, 1'(i == 0), 1'b1}), 27'({a_oe, a_b}));
        end
        {a_i, sad, idle} = '0;
        for (int f = 0; f < 4; f++) begin
            // Rising-edge sampling first, then falling edge, each with filter off and on
            {sel, filt} = {1'(f < 2), 1'(f % 2)};
            {run, seen_ls, seen_pv, seen_cst, have} = 5'b10000;
            step(8);
            mon = 1'b1;
            for (int k = 0; k < 600; k++) begin
                rdy = (k % 50) < 40;
                step(1);
            end
            {mon, run, rdy} = 3'b001;
            step(8);
            chk("sync_seen", 27'({1'(f % 2 == 0), 2'b11}),
                27'({seen_ls, seen_pv, seen_cst}));
        end
        report_and_stop();
    end
endmodule : tb_top
